// >>> tmw_pkg.sv
// constants, register map and mode codes of the 8-bit waveform timer
// assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data
//
// What this block does
// - output mode zero leaves output state unchanged
// - output mode acts at next match; force acts now in normal and ctc modes only
// - normal mode counts up, wraps max to zero
// - normal mode sets overflow flag entering zero
// - ctc clears counter on the match tick
// - ctc compare writes are immediate, may miss match
// - ctc toggle mode inverts output every match
// - ctc sets overflow flag stepping max to zero
// - pin driven only when direction selects output
// - fast pwm counts bottom to max, then clears
// - fast pwm clears/sets on match, opposite at bottom
// - fast pwm sets overflow flag at max
// - fast pwm extremes give spike or constant level
// - fast pwm toggle mode gives square wave, buffered
// - fast pwm period is 256 ticks
// - phase pwm counts up, turns at max without holding, down
// - phase pwm clears/sets up-match, opposite down-match
// - phase pwm sets overflow flag at bottom
// - phase pwm period is 510 ticks
// - phase pwm extremes hold output low or high
// - at max output takes up-count match result, down-count result if compare is max
// - pwm compare buffered to max, others direct
// - a match sets compare flag next tick
// - count write blocks next-tick match, has priority
// - clock select zero stops the counter
package tmw_pkg;

	// ----------------------------------------
	// bus and register map
	// ----------------------------------------
	localparam int TMW_ADDR_W = 4;
	localparam logic [TMW_ADDR_W-1:0] TMW_OFF_CTRL = 4'h0;
	localparam logic [TMW_ADDR_W-1:0] TMW_OFF_COUNT = 4'h4;
	localparam logic [TMW_ADDR_W-1:0] TMW_OFF_COMPARE = 4'h8;
	localparam logic [TMW_ADDR_W-1:0] TMW_OFF_FLAGS = 4'hC;
	localparam logic [1:0] TMW_RESP_OKAY = 2'h0;
	localparam logic [1:0] TMW_RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TMW_CTRL_MODE_LSB = 0;
	localparam int TMW_CTRL_COM_LSB = 2;
	localparam int TMW_CTRL_CS_LSB = 4;
	localparam int TMW_CTRL_FORCE_BIT = 7;
	localparam int TMW_CTRL_PINDIR_BIT = 8;
	localparam int TMW_FLAG_OVF_BIT = 0;
	localparam int TMW_FLAG_CMP_BIT = 1;
	localparam int TMW_FLAG_DIR_BIT = 2;

	// ----------------------------------------
	// counter limits and reset values
	// ----------------------------------------
	localparam logic [7:0] TMW_MAX = 8'hFF;
	localparam logic [7:0] TMW_BOTTOM = 8'h00;
	localparam logic [7:0] TMW_ONE = 8'h01;
	localparam logic [7:0] TMW_RST_BYTE = 8'h00;
	localparam logic [31:0] TMW_RST_WORD = 32'h0000_0000;

	// ----------------------------------------
	// modes and clock sources
	// ----------------------------------------
	typedef enum logic [1:0] {
		TMW_WM_NORMAL = 2'h0,
		TMW_WM_PHASE = 2'h1,
		TMW_WM_CTC = 2'h2,
		TMW_WM_FAST = 2'h3
	} tmw_wave_e;

	localparam logic [1:0] TMW_COM_OFF = 2'h0;
	localparam logic [1:0] TMW_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TMW_COM_CLEAR = 2'h2;
	localparam logic [1:0] TMW_COM_SET = 2'h3;

	localparam logic [2:0] TMW_CS_STOP = 3'h0;
	localparam logic [2:0] TMW_CS_DIV1 = 3'h1;
	localparam logic [2:0] TMW_CS_DIV8 = 3'h2;
	localparam logic [2:0] TMW_CS_DIV64 = 3'h3;
	localparam logic [2:0] TMW_CS_DIV256 = 3'h4;
	localparam logic [2:0] TMW_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TMW_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TMW_CS_EXT_RISE = 3'h7;

	localparam int TMW_PRESC_W = 10;
	localparam logic [TMW_PRESC_W-1:0] TMW_PRESC_M8 = 10'h007;
	localparam logic [TMW_PRESC_W-1:0] TMW_PRESC_M64 = 10'h03F;
	localparam logic [TMW_PRESC_W-1:0] TMW_PRESC_M256 = 10'h0FF;
	localparam logic [TMW_PRESC_W-1:0] TMW_PRESC_M1024 = 10'h3FF;
	localparam logic [TMW_PRESC_W-1:0] TMW_PRESC_STEP = 10'h001;
	localparam logic [TMW_PRESC_W-1:0] TMW_PRESC_RST = 10'h000;

endpackage

// >>> tmw_timer.sv
// 8-bit timer with normal, ctc, fast pwm and phase pwm waveform modes
// assumes an AXI4-Lite master on aclk and an asynchronous external count pin
`timescale 1ns/10ps
module tmw_timer
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tmw_pkg::TMW_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tmw_pkg::TMW_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_count_pin,
	output logic compare_output_pin,
	output logic compare_output_pin_oe,
	output logic overflow_flag,
	output logic compare_flag
);
	import tmw_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic aw_have_q;
	logic [TMW_ADDR_W-1:0] aw_addr_q;
	logic w_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic wr_ctrl;
	logic wr_count;
	logic wr_compare;
	logic wr_flags;
	logic [31:0] ctrl_word;
	logic [31:0] ctrl_new;
	tmw_wave_e mode_q;
	logic [1:0] com_q;
	logic [2:0] cs_q;
	logic pin_dir_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic dir_up_q;
	logic dir_up_d;
	logic [7:0] ocr_buf_q;
	logic [7:0] ocr_act_q;
	logic block_q;
	logic match_pend_q;
	logic ovf_q;
	logic cmp_q;
	logic oc_q;
	logic oc_d;
	logic [TMW_PRESC_W-1:0] presc_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic ext_stable_q;
	logic ext_rise;
	logic ext_fall;
	logic tick;
	logic is_pwm;
	logic at_max;
	logic at_bot;
	logic match_raw;
	logic ovf_set;
	logic force_fire;
	logic up_res;
	logic down_res;
	logic up_now;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] tmw_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic tmw_nonpwm_act(input logic [1:0] com, input logic cur);
		logic res;
		res = cur;
		unique case (com)
			TMW_COM_OFF: res = cur;
			TMW_COM_TOGGLE: res = ~cur;
			TMW_COM_CLEAR: res = 1'b0;
			TMW_COM_SET: res = 1'b1;
		endcase
		return res;
	endfunction

	function automatic logic tmw_mapped(input logic [TMW_ADDR_W-1:0] a);
		return (a == TMW_OFF_CTRL) || (a == TMW_OFF_COUNT) || (a == TMW_OFF_COMPARE) || (a == TMW_OFF_FLAGS);
	endfunction

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready = ~w_have_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign wr_ctrl = wr_fire & (aw_addr_q == TMW_OFF_CTRL);
	assign wr_count = wr_fire & (aw_addr_q == TMW_OFF_COUNT) & w_strb_q[0];
	assign wr_compare = wr_fire & (aw_addr_q == TMW_OFF_COMPARE) & w_strb_q[0];
	assign wr_flags = wr_fire & (aw_addr_q == TMW_OFF_FLAGS) & w_strb_q[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_have_q <= 1'b0;
			w_data_q <= TMW_RST_WORD;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= TMW_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= tmw_mapped(aw_addr_q) ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= TMW_RST_WORD;
			rresp_q <= TMW_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= tmw_mapped(s_axi_araddr) ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
			rdata_q <= TMW_RST_WORD;
			unique case (s_axi_araddr)
				TMW_OFF_CTRL: rdata_q <= ctrl_word;
				TMW_OFF_COUNT: rdata_q[7:0] <= cnt_q;
				TMW_OFF_COMPARE: rdata_q[7:0] <= ocr_buf_q;
				TMW_OFF_FLAGS:
				begin
					rdata_q[TMW_FLAG_OVF_BIT] <= ovf_q;
					rdata_q[TMW_FLAG_CMP_BIT] <= cmp_q;
					rdata_q[TMW_FLAG_DIR_BIT] <= dir_up_q;
				end
				default: rdata_q <= TMW_RST_WORD;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_comb
	begin
		ctrl_word = TMW_RST_WORD;
		ctrl_word[TMW_CTRL_MODE_LSB +: 2] = mode_q;
		ctrl_word[TMW_CTRL_COM_LSB +: 2] = com_q;
		ctrl_word[TMW_CTRL_CS_LSB +: 3] = cs_q;
		ctrl_word[TMW_CTRL_PINDIR_BIT] = pin_dir_q;
	end

	assign ctrl_new = tmw_merge(ctrl_word, w_data_q, w_strb_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_q <= TMW_WM_NORMAL;
			com_q <= TMW_COM_OFF;
			cs_q <= TMW_CS_STOP;
			pin_dir_q <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			mode_q <= tmw_wave_e'(ctrl_new[TMW_CTRL_MODE_LSB +: 2]);
			com_q <= ctrl_new[TMW_CTRL_COM_LSB +: 2];
			cs_q <= ctrl_new[TMW_CTRL_CS_LSB +: 3];
			pin_dir_q <= ctrl_new[TMW_CTRL_PINDIR_BIT];
		end
	end

	// force strobe uses the mode and output mode written with it
	assign force_fire = wr_ctrl & w_strb_q[0] & w_data_q[TMW_CTRL_FORCE_BIT]
		& ~ctrl_new[TMW_CTRL_MODE_LSB];

	// ----------------------------------------
	// tick generation
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			presc_q <= TMW_PRESC_RST;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_stable_q <= 1'b0;
		end
		else
		begin
			presc_q <= presc_q + TMW_PRESC_STEP;
			ext_s1_q <= ext_count_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q)
			begin
				ext_stable_q <= ext_s3_q;
			end
		end
	end

	assign ext_rise = (ext_s2_q == ext_s3_q) & ext_s3_q & ~ext_stable_q;
	assign ext_fall = (ext_s2_q == ext_s3_q) & ~ext_s3_q & ext_stable_q;

	always_comb
	begin
		tick = 1'b0;
		unique case (cs_q)
			TMW_CS_STOP: tick = 1'b0;
			TMW_CS_DIV1: tick = 1'b1;
			TMW_CS_DIV8: tick = (presc_q & TMW_PRESC_M8) == TMW_PRESC_M8;
			TMW_CS_DIV64: tick = (presc_q & TMW_PRESC_M64) == TMW_PRESC_M64;
			TMW_CS_DIV256: tick = (presc_q & TMW_PRESC_M256) == TMW_PRESC_M256;
			TMW_CS_DIV1024: tick = presc_q == TMW_PRESC_M1024;
			TMW_CS_EXT_FALL: tick = ext_fall;
			TMW_CS_EXT_RISE: tick = ext_rise;
		endcase
	end

	// ----------------------------------------
	// counter unit
	// ----------------------------------------
	assign is_pwm = (mode_q == TMW_WM_PHASE) || (mode_q == TMW_WM_FAST);
	assign at_max = cnt_q == TMW_MAX;
	assign at_bot = cnt_q == TMW_BOTTOM;
	assign match_raw = (cnt_q == ocr_act_q) & ~block_q;

	always_comb
	begin
		cnt_d = cnt_q + TMW_ONE;
		dir_up_d = 1'b1;
		unique case (mode_q)
			TMW_WM_NORMAL: cnt_d = cnt_q + TMW_ONE;
			TMW_WM_CTC: cnt_d = match_raw ? TMW_BOTTOM : cnt_q + TMW_ONE;
			TMW_WM_FAST: cnt_d = at_max ? TMW_BOTTOM : cnt_q + TMW_ONE;
			TMW_WM_PHASE:
			begin
				dir_up_d = dir_up_q ? ~at_max : at_bot;
				cnt_d = dir_up_d ? cnt_q + TMW_ONE : cnt_q - TMW_ONE;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q <= TMW_RST_BYTE;
			dir_up_q <= 1'b1;
		end
		else if (wr_count)
		begin
			cnt_q <= w_data_q[7:0];
		end
		else if (tick)
		begin
			cnt_q <= cnt_d;
			dir_up_q <= dir_up_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			block_q <= 1'b0;
		end
		else if (wr_count)
		begin
			block_q <= 1'b1;
		end
		else if (tick)
		begin
			block_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// compare value buffering
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ocr_buf_q <= TMW_RST_BYTE;
			ocr_act_q <= TMW_RST_BYTE;
		end
		else
		begin
			if (wr_compare)
			begin
				ocr_buf_q <= w_data_q[7:0];
			end
			if (!is_pwm)
			begin
				ocr_act_q <= wr_compare ? w_data_q[7:0] : ocr_buf_q;
			end
			else if (tick && at_max && !wr_count)
			begin
				ocr_act_q <= ocr_buf_q;
			end
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	// normal, ctc, fast: step out of max; phase: step into bottom
	assign ovf_set = tick & ~wr_count & (is_pwm && mode_q == TMW_WM_PHASE ? (cnt_d == TMW_BOTTOM) : at_max);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovf_q <= 1'b0;
			cmp_q <= 1'b0;
			match_pend_q <= 1'b0;
		end
		else
		begin
			if (tick)
			begin
				match_pend_q <= match_raw;
			end
			if (ovf_set)
			begin
				ovf_q <= 1'b1;
			end
			else if (wr_flags && w_data_q[TMW_FLAG_OVF_BIT])
			begin
				ovf_q <= 1'b0;
			end
			if (tick && match_pend_q)
			begin
				cmp_q <= 1'b1;
			end
			else if (wr_flags && w_data_q[TMW_FLAG_CMP_BIT])
			begin
				cmp_q <= 1'b0;
			end
		end
	end

	assign overflow_flag = ovf_q;
	assign compare_flag = cmp_q;

	// ----------------------------------------
	// waveform generator
	// ----------------------------------------
	assign up_res = com_q[0];
	assign down_res = ~com_q[0];
	assign up_now = at_bot | dir_up_q;

	always_comb
	begin
		oc_d = oc_q;
		unique case (mode_q)
			TMW_WM_NORMAL, TMW_WM_CTC:
			begin
				if (tick && match_raw)
				begin
					oc_d = tmw_nonpwm_act(com_q, oc_q);
				end
			end
			TMW_WM_FAST:
			begin
				if (tick && at_max && com_q[1])
				begin
					oc_d = ~com_q[0];
				end
				else if (tick && match_raw)
				begin
					oc_d = tmw_nonpwm_act(com_q, oc_q);
				end
			end
			TMW_WM_PHASE:
			begin
				if (tick && com_q[1] && at_max)
				begin
					oc_d = (ocr_act_q == TMW_MAX) ? down_res : up_res;
				end
				else if (tick && com_q[1] && match_raw)
				begin
					oc_d = up_now ? up_res : down_res;
				end
			end
		endcase
		// force acts now with the output mode written with it
		if (force_fire)
		begin
			oc_d = tmw_nonpwm_act(ctrl_new[TMW_CTRL_COM_LSB +: 2], oc_q);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oc_q <= 1'b0;
		end
		else
		begin
			oc_q <= oc_d;
		end
	end

	assign compare_output_pin = oc_q;
	assign compare_output_pin_oe = pin_dir_q & (com_q != TMW_COM_OFF);

endmodule

// >>> tmw_load.sv
// load model on the compare output pin: a pad with a pull-down
// assumes the timer's pin and pin enable outputs feed it
`timescale 1ns/10ps
module tmw_load
(
	input wire logic pin,
	input wire logic pin_oe,
	output logic pad
);
	// a released pad falls to the pull-down level
	assign pad = pin_oe ? pin : 1'b0;
endmodule

// >>> tmw_timer_props.sv
// assertions on bus handshakes, sticky flags and pin enable of the timer
// assumes it is bound to tmw_timer and sees its ports only
`timescale 1ns/10ps
module tmw_timer_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic compare_output_pin_oe,
	input wire logic overflow_flag,
	input wire logic compare_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	ovf_sticky_a: assert property ($past(aresetn) && $fell(overflow_flag) |->
		$past(s_axi_awvalid || s_axi_wvalid) || $past(s_axi_awvalid || s_axi_wvalid, 2))
		else $error("overflow flag lost without write");
	cmp_sticky_a: assert property ($past(aresetn) && $fell(compare_flag) |->
		$past(s_axi_awvalid || s_axi_wvalid) || $past(s_axi_awvalid || s_axi_wvalid, 2))
		else $error("compare flag lost without write");
	oe_write_a: assert property ($past(aresetn) && $changed(compare_output_pin_oe) |->
		$past(s_axi_awvalid || s_axi_wvalid) || $past(s_axi_awvalid || s_axi_wvalid, 2))
		else $error("pin enable moved without write");
endmodule
bind tmw_timer tmw_timer_props i_tmw_timer_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .compare_output_pin_oe(compare_output_pin_oe),
	.overflow_flag(overflow_flag), .compare_flag(compare_flag));

// >>> tb_tmw_timer.sv
// self-checking bench of the waveform timer
// assumes tmw_pkg, tmw_timer, tmw_load and the bound checker
`timescale 1ns/10ps
module tb_tmw_timer;
	import tmw_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [TMW_ADDR_W-1:0] awaddr = 4'h0;
	logic [TMW_ADDR_W-1:0] araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic ext_pin = 1'b0;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, pin, oe, ovf, cmpf, pad;
	int error_cnt = 0;
	int compares = 0;
	always #4 aclk = ~aclk;
	tmw_timer i_tmw_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_count_pin(ext_pin),
		.compare_output_pin(pin), .compare_output_pin_oe(oe), .overflow_flag(ovf), .compare_flag(cmpf));
	tmw_load i_tmw_load (.pin(pin), .pin_oe(oe), .pad(pad));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_sim;
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang;
		error_cnt++;
		end_sim;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] c, input logic [2:0] s,
		input logic f, input logic d);
		return {23'h0, d, f, s, c, m};
	endfunction
	task automatic axi_wr(input logic [TMW_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ap, wp, bh;
		logic [1:0] r;
		n = 0;
		ap = 1'b1;
		wp = 1'b1;
		bh = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bh)
		begin
			@(negedge aclk);
			ap = ap && !awready;
			wp = wp && !wready;
			bh = bvalid;
			r = bresp;
			@(posedge aclk);
			awvalid <= ap;
			wvalid <= wp;
			bready <= !bh;
			n++;
			if (n > 200)
				hang;
		end
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic axi_rd(input logic [TMW_ADDR_W-1:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		logic ap, rh;
		logic [1:0] r;
		n = 0;
		ap = 1'b1;
		rh = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rh)
		begin
			@(negedge aclk);
			ap = ap && !arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			arvalid <= ap;
			rready <= !rh;
			n++;
			if (n > 200)
				hang;
		end
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic wait_lvl(input logic v, output int n);
		n = 0;
		while (pin !== v)
		begin
			@(negedge aclk);
			n++;
			if (n > 2000)
				hang;
		end
	endtask
	task automatic meas(output int hi, output int per);
		int n;
		wait_lvl(1'b0, n);
		wait_lvl(1'b1, n);
		wait_lvl(1'b0, hi);
		wait_lvl(1'b1, n);
		per = hi + n;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_regs;
		logic [31:0] d;
		axi_rd(TMW_OFF_CTRL, d, TMW_RESP_OKAY);
		chk(d, TMW_RST_WORD);
		axi_rd(TMW_OFF_COMPARE, d, TMW_RESP_OKAY);
		chk(d, TMW_RST_WORD);
		axi_rd(4'h2, d, TMW_RESP_SLVERR);
		axi_wr(4'h6, 32'h1, TMW_RESP_SLVERR);
		axi_wr(TMW_OFF_COUNT, 32'h5A, TMW_RESP_OKAY);
		repeat (30) @(posedge aclk);
		axi_rd(TMW_OFF_COUNT, d, TMW_RESP_OKAY);
		chk(d, 32'h5A);
	endtask
	task automatic s_normal;
		int n;
		axi_wr(TMW_OFF_COUNT, 32'hF0, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_COMPARE, 32'h10, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_FLAGS, 32'h3, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_NORMAL, TMW_COM_OFF, TMW_CS_DIV1, 1'b0, 1'b0), TMW_RESP_OKAY);
		for (n = 0; ovf !== 1'b1 && n < 300; n++)
			@(negedge aclk);
		chk({31'h0, n > 11 && n < 18}, 32'h1);
		axi_wr(TMW_OFF_FLAGS, 32'h1, TMW_RESP_OKAY);
		@(negedge aclk);
		chk({31'h0, ovf}, 32'h0);
		for (n = 0; ovf !== 1'b1 && n < 300; n++)
			@(negedge aclk);
		chk({31'h0, n > 230 && n < 256}, 32'h1);
		chk({31'h0, cmpf}, 32'h1);
		axi_wr(TMW_OFF_CTRL, TMW_RST_WORD, TMW_RESP_OKAY);
	endtask
	task automatic s_block;
		int n;
		axi_wr(TMW_OFF_COMPARE, 32'h20, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_COUNT, 32'h20, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_FLAGS, 32'h3, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_NORMAL, TMW_COM_OFF, TMW_CS_DIV1, 1'b0, 1'b0), TMW_RESP_OKAY);
		repeat (20) @(negedge aclk);
		chk({31'h0, cmpf}, 32'h0);
		repeat (260) @(negedge aclk);
		chk({31'h0, cmpf}, 32'h1);
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_CTC, TMW_COM_OFF, TMW_CS_STOP, 1'b0, 1'b0), TMW_RESP_OKAY);
		axi_wr(TMW_OFF_COMPARE, 32'h10, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_COUNT, 32'h40, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_FLAGS, 32'h3, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_CTC, TMW_COM_OFF, TMW_CS_DIV1, 1'b0, 1'b0), TMW_RESP_OKAY);
		for (n = 0; ovf !== 1'b1 && n < 300; n++)
			@(negedge aclk);
		chk({31'h0, n > 185 && n < 200}, 32'h1);
	endtask
	task automatic s_clk;
		logic [31:0] d;
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_NORMAL, TMW_COM_OFF, TMW_CS_DIV8, 1'b0, 1'b0), TMW_RESP_OKAY);
		axi_wr(TMW_OFF_COUNT, 32'h0, TMW_RESP_OKAY);
		repeat (800) @(posedge aclk);
		axi_rd(TMW_OFF_COUNT, d, TMW_RESP_OKAY);
		chk({31'h0, d > 32'd97 && d < 32'd104}, 32'h1);
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_NORMAL, TMW_COM_OFF, TMW_CS_EXT_RISE, 1'b0, 1'b0), TMW_RESP_OKAY);
		axi_wr(TMW_OFF_COUNT, 32'h0, TMW_RESP_OKAY);
		repeat (10)
		begin
			repeat (8) @(posedge aclk);
			ext_pin <= 1'b1;
			repeat (8) @(posedge aclk);
			ext_pin <= 1'b0;
		end
		repeat (8) @(posedge aclk);
		axi_rd(TMW_OFF_COUNT, d, TMW_RESP_OKAY);
		chk(d, 32'hA);
	endtask
	task automatic s_force;
		logic [1:0] c[4] = '{TMW_COM_CLEAR, TMW_COM_SET, TMW_COM_TOGGLE, TMW_COM_TOGGLE};
		logic e[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++)
		begin
			axi_wr(TMW_OFF_CTRL, cw(TMW_WM_NORMAL, c[i], TMW_CS_STOP, 1'b1, 1'b1), TMW_RESP_OKAY);
			@(negedge aclk);
			chk({31'h0, pin}, {31'h0, e[i]});
			chk({31'h0, pad}, {31'h0, e[i]});
		end
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_NORMAL, TMW_COM_OFF, TMW_CS_STOP, 1'b1, 1'b1), TMW_RESP_OKAY);
		@(negedge aclk);
		chk({31'h0, pin}, 32'h1);
		chk({31'h0, oe}, 32'h0);
		chk({31'h0, pad}, 32'h0);
	endtask
	task automatic s_mode(input tmw_wave_e m, input logic [7:0] v, input logic [1:0] c, input int hi, input int per);
		int h;
		int p;
		axi_wr(TMW_OFF_COMPARE, {24'h0, v}, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_CTRL, cw(m, c, TMW_CS_DIV1, 1'b0, 1'b1), TMW_RESP_OKAY);
		meas(h, p);
		meas(h, p);
		chk(h, hi);
		chk(p, per);
		chk({31'h0, pad}, {31'h0, pin});
		axi_wr(TMW_OFF_FLAGS, 32'h3, TMW_RESP_OKAY);
		for (h = 0; ovf !== 1'b1 && h < 600; h++)
			@(negedge aclk);
		chk({31'h0, h < 520}, {31'h0, m != TMW_WM_CTC});
	endtask
	task automatic s_level(input logic [7:0] v, input logic [1:0] c, input logic e);
		int n;
		n = 0;
		axi_wr(TMW_OFF_COMPARE, {24'h0, v}, TMW_RESP_OKAY);
		axi_wr(TMW_OFF_CTRL, cw(TMW_WM_PHASE, c, TMW_CS_DIV1, 1'b0, 1'b1), TMW_RESP_OKAY);
		repeat (1100) @(negedge aclk);
		repeat (520)
		begin
			@(negedge aclk);
			n += (pin !== e);
		end
		chk(n, 0);
	endtask
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		s_regs;
		s_normal;
		s_block;
		s_clk;
		s_force;
		s_mode(TMW_WM_CTC, 8'h03, TMW_COM_TOGGLE, 4, 8);
		s_mode(TMW_WM_FAST, 8'h80, TMW_COM_CLEAR, 129, 256);
		s_mode(TMW_WM_FAST, 8'h80, TMW_COM_SET, 127, 256);
		s_mode(TMW_WM_FAST, 8'h00, TMW_COM_CLEAR, 1, 256);
		s_mode(TMW_WM_FAST, 8'h80, TMW_COM_TOGGLE, 256, 512);
		s_mode(TMW_WM_PHASE, 8'h40, TMW_COM_CLEAR, 128, 510);
		s_mode(TMW_WM_PHASE, 8'h40, TMW_COM_SET, 382, 510);
		s_level(8'h00, TMW_COM_CLEAR, 1'b0);
		s_level(8'hFF, TMW_COM_CLEAR, 1'b1);
		s_level(8'h00, TMW_COM_SET, 1'b1);
		end_sim;
	end
endmodule
